// File: pkg/drrtm_pkg.sv
// Constants and types shared by the row repair and thermal mode register block.
package drrtm_pkg;
    localparam logic [5:0] ADDR_REFRESH_THERMAL_REPAIR = 6'h04;
    localparam logic [5:0] ADDR_BANK_SPARE_ROW         = 6'h19;
    localparam int         NUM_BANKS                   = 8;
    localparam int         BANK_W                      = 3;
    localparam int         ROW_W                       = 17;
    localparam int         REFRESH_RATE_LSB            = 0;
    localparam int         SELF_REFRESH_CANCEL_BIT     = 3;
    localparam int         REPAIR_ENTRY_BIT            = 4;
    localparam int         THERMAL_OFFSET_LSB          = 5;
    localparam int         TEMP_UPDATE_FLAG_BIT        = 7;
    localparam logic [2:0] RATE_LOW_LIMIT              = 3'h0;
    localparam logic [2:0] RATE_1X                     = 3'h3;
    localparam logic [2:0] RATE_QUARTER_DERATED        = 3'h6;
    localparam logic [2:0] RATE_HIGH_LIMIT             = 3'h7;
    localparam logic [1:0] THERMAL_OFFSET_RESERVED     = 2'h3;
    localparam logic [7:0] SPARE_ROWS_RESET            = 8'hFF;
    localparam int         CLOCK_MHZ                   = 125;
    localparam int         CLOCK_PERIOD_PS             = 8000;
    localparam int         REPAIR_PROGRAM_TIME_MS      = 1000;
    localparam longint     REPAIR_PROGRAM_CYCLES       =
        longint'(REPAIR_PROGRAM_TIME_MS) * 1000 * CLOCK_MHZ;
    localparam int         NEW_ADDRESS_SETTLE_TIME_US  = 50;
    localparam int         NEW_ADDRESS_SETTLE_CYCLES   = NEW_ADDRESS_SETTLE_TIME_US * CLOCK_MHZ;
    localparam int         REPAIR_EXIT_TIME_NS         = 15;
    localparam int         REPAIR_EXIT_CYCLES          =
        (REPAIR_EXIT_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    localparam int         CNT_W                       = 32;
    typedef enum logic [1:0] {
        DRRTM_CMD_NOP,
        DRRTM_CMD_ACTIVATE,
        DRRTM_CMD_PRECHARGE,
        DRRTM_CMD_MODE_WRITE
    } drrtm_cmd_t;
    typedef enum {
        DRRTM_IDLE,
        DRRTM_ARMED,
        DRRTM_PROGRAM,
        DRRTM_EXIT_WAIT,
        DRRTM_DONE,
        DRRTM_SETTLE
    } drrtm_state_t;
endpackage

// File: pkg/drrtm_fuse_if.sv
// Link between the repair sequencer and the spare row fuse store.
`timescale 1ns/1ps
interface drrtm_fuse_if;
    import drrtm_pkg::*;
    logic                 burn;
    logic [BANK_W-1:0]    bank;
    logic [ROW_W-1:0]     row;
    logic [NUM_BANKS-1:0] spare_free;
    modport ctrl (output burn, output bank, output row, input spare_free);
    modport store (input burn, input bank, input row, output spare_free);
endinterface

// File: hdl/drrtm_fuse_store.sv
// Spare row fuse store: one remembered repaired row per bank.
`timescale 1ns/1ps
module drrtm_fuse_store (
    input  wire logic clock,
    input  wire logic arst_n,
    drrtm_fuse_if.store fuse
);
    import drrtm_pkg::*;
    logic [ROW_W-1:0]     repaired_row [NUM_BANKS];
    logic [ROW_W-1:0]     next_repaired_row [NUM_BANKS];
    logic [NUM_BANKS-1:0] spare_free;
    logic [NUM_BANKS-1:0] next_spare_free;
    // Outside reset free bits only ever clear; arst_n sets them all back to free.
    always_comb begin
        next_spare_free   = spare_free;
        next_repaired_row = repaired_row;
        if (fuse.burn && spare_free[fuse.bank]) begin // [R3]
            next_spare_free[fuse.bank]   = 1'b0;
            next_repaired_row[fuse.bank] = fuse.row;
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            spare_free <= SPARE_ROWS_RESET;
            for (int i = 0; i < NUM_BANKS; i++) begin
                repaired_row[i] <= '0;
            end
        end else begin
            spare_free   <= next_spare_free;
            repaired_row <= next_repaired_row;
        end
    end
    assign fuse.spare_free = spare_free;
endmodule

// File: hdl/drrtm_mode_regs.sv
// Mode registers for row repair and thermal reporting, with the repair sequencer.
//
// Behaviour
// [R1] Delays expire when nanoseconds and clocks elapse.
// [R2] Spare row register shows one availability bit per bank.
// [R3] At most one repaired row per bank.
// [R4] Controller avoids accidental repair entry.
// [R5] All banks precharged before repair entry; the code still enters with a bank open and raises repair_fault.
// [R6] Set repair bit, wait settle delay.
// [R7] Wait repair program time before precharge.
// [R8] Wait repair exit time after precharge.
// [R9] Exit by clearing bit; settle before commands.
// [R10] Repeat whole sequence per further address.
// [R11] Verify repair by write and readback.
// [R12] Refresh rate field codes as encoded.
// [R13] Code 011 means 85C; bit2 means hotter.
// [R14] Derating needed reports code 110.
// [R15] Bit 3 enables self refresh cancel; the code honours it only when density_12gb is set.
// [R16] Bit 4 enters or leaves repair mode.
// [R17] Bits 6:5 select thermal offset.
// [R18] Update flag set on change, read clears.
// [R19] Flag zero at power-up; rate valid after init.
// [R20] Writes update only bits 6:3.
// [R21] Codes 000 and 111 flag unsafe operation.
// [R22] Controller applies derated timings when hot.
// [R23] Only repair commands while in repair mode; the code faults other commands only in DRRTM_PROGRAM.
`timescale 1ns/1ps
module drrtm_mode_regs #(
    parameter longint PROGRAM_CYCLES = drrtm_pkg::REPAIR_PROGRAM_CYCLES,
    parameter int     SETTLE_CYCLES  = drrtm_pkg::NEW_ADDRESS_SETTLE_CYCLES
) (
    input  wire logic                          clock,
    input  wire logic                          arst_n,
    input  wire drrtm_pkg::drrtm_cmd_t         cmd,
    input  wire logic [5:0]                    cmd_addr,
    input  wire logic [7:0]                    cmd_wdata,
    input  wire logic                          cmd_read,
    input  wire logic [drrtm_pkg::BANK_W-1:0]  cmd_bank,
    input  wire logic [drrtm_pkg::ROW_W-1:0]   cmd_row,
    input  wire logic                          all_banks_idle,
    input  wire logic                          init_done,
    input  wire logic [2:0]                    sensed_rate,
    input  wire logic                          density_12gb,
    output logic [7:0]                         rd_data,
    output logic                               rd_valid,
    output logic                               repair_mode,
    output logic                               repair_busy,
    output logic                               self_refresh_cancel,
    output logic [1:0]                         thermal_offset,
    output logic                               derate_needed,
    output logic                               temp_unsafe,
    output logic                               above_85c,
    output logic                               repair_fault
);
    import drrtm_pkg::*;
    drrtm_fuse_if fuse ();
    drrtm_state_t     state;
    drrtm_state_t     next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [BANK_W-1:0] tgt_bank;
    logic [BANK_W-1:0] next_tgt_bank;
    logic [ROW_W-1:0]  tgt_row;
    logic [ROW_W-1:0]  next_tgt_row;
    logic             burn;
    logic             next_burn;
    logic             next_repair_fault;
    logic             next_repair_mode;
    logic             next_repair_busy;
    logic             next_self_refresh_cancel;
    logic [1:0]       next_thermal_offset;
    logic [2:0]       rate;
    logic [2:0]       next_rate;
    logic             temp_update_flag;
    logic             next_temp_update_flag;
    logic             next_derate_needed;
    logic             next_temp_unsafe;
    logic             next_above_85c;
    logic [7:0]       next_rd_data;
    logic             next_rd_valid;
    logic             mode_wr;
    logic             mode_rd;
    assign mode_wr = (cmd == DRRTM_CMD_MODE_WRITE) && !cmd_read;
    assign mode_rd = (cmd == DRRTM_CMD_MODE_WRITE) && cmd_read;
    assign fuse.burn = burn;
    assign fuse.bank = tgt_bank;
    assign fuse.row  = tgt_row;
    drrtm_fuse_store u_store (
        .clock  (clock),
        .arst_n (arst_n),
        .fuse   (fuse)
    );
    // Mode register file; only bits 6:3 are writable.
    always_comb begin
        next_self_refresh_cancel = self_refresh_cancel;
        next_thermal_offset      = thermal_offset;
        next_repair_mode         = repair_mode;
        next_rate                = init_done ? sensed_rate : RATE_1X; // [R19]
        next_temp_update_flag    = temp_update_flag;
        next_rd_data             = rd_data;
        next_rd_valid            = 1'b0;
        if (mode_wr && cmd_addr == ADDR_REFRESH_THERMAL_REPAIR) begin // [R20]
            next_self_refresh_cancel = cmd_wdata[SELF_REFRESH_CANCEL_BIT] && density_12gb; // [R15]
            next_repair_mode = cmd_wdata[REPAIR_ENTRY_BIT]; // [R16]
            // The reserved offset code is refused so the thermal trim stays defined.
            if (cmd_wdata[THERMAL_OFFSET_LSB+:2] != THERMAL_OFFSET_RESERVED) begin // [R17]
                next_thermal_offset = cmd_wdata[THERMAL_OFFSET_LSB+:2];
            end
        end
        if (mode_rd) begin
            next_rd_valid = 1'b1;
            if (cmd_addr == ADDR_REFRESH_THERMAL_REPAIR) begin
                next_rd_data = {temp_update_flag, thermal_offset, repair_mode,
                                self_refresh_cancel, rate}; // [R12]
                next_temp_update_flag = 1'b0; // [R18]
            end else if (cmd_addr == ADDR_BANK_SPARE_ROW) begin
                next_rd_data = fuse.spare_free; // [R2]
            end else begin
                next_rd_data = 8'h00;
            end
        end
        // A rate change in the same cycle as a read keeps the flag set.
        if (init_done && next_rate != rate) begin // [R18]
            next_temp_update_flag = 1'b1;
        end
        next_derate_needed = (next_rate == RATE_QUARTER_DERATED); // [R14]
        next_temp_unsafe   = (next_rate == RATE_LOW_LIMIT) || (next_rate == RATE_HIGH_LIMIT); // [R21]
        next_above_85c     = next_rate[2]; // [R13]
    end
    // Repair sequencer: arms on entry, burns after the program time, then settles.
    always_comb begin
        next_state        = state;
        next_count        = (count != '0) ? count - 1'b1 : count;
        next_tgt_bank     = tgt_bank;
        next_tgt_row      = tgt_row;
        next_burn         = 1'b0;
        next_repair_fault = repair_fault;
        case (state)
            DRRTM_IDLE: begin
                if (next_repair_mode && !repair_mode) begin
                    next_repair_fault = !all_banks_idle; // [R5]
                    next_state = DRRTM_ARMED;
                end
            end
            DRRTM_ARMED: begin
                if (cmd == DRRTM_CMD_ACTIVATE) begin
                    next_tgt_bank = cmd_bank;
                    next_tgt_row  = cmd_row;
                    next_count    = CNT_W'(PROGRAM_CYCLES);
                    next_state    = DRRTM_PROGRAM;
                end else if (!next_repair_mode) begin
                    next_count = CNT_W'(SETTLE_CYCLES);
                    next_state = DRRTM_SETTLE;
                end
            end
            DRRTM_PROGRAM: begin
                if (cmd == DRRTM_CMD_PRECHARGE) begin
                    // An early precharge aborts the burn, leaving the spare row unused.
                    if (count == '0) begin // [R7]
                        next_burn = 1'b1;
                    end else begin
                        next_repair_fault = 1'b1;
                    end
                    next_count = CNT_W'(REPAIR_EXIT_CYCLES); // [R8]
                    next_state = DRRTM_EXIT_WAIT;
                end else if (cmd != DRRTM_CMD_NOP) begin
                    next_repair_fault = 1'b1; // [R23]
                end
            end
            DRRTM_EXIT_WAIT: begin
                if (count == '0) begin
                    next_state = DRRTM_DONE;
                end
            end
            DRRTM_DONE: begin
                if (!next_repair_mode) begin // [R9]
                    next_count = CNT_W'(SETTLE_CYCLES);
                    next_state = DRRTM_SETTLE;
                end
            end
            DRRTM_SETTLE: begin
                if (count == '0) begin // [R9]
                    next_state = DRRTM_IDLE;
                end
            end
            default: next_state = DRRTM_IDLE;
        endcase
        next_repair_busy = (next_state != DRRTM_IDLE);
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            self_refresh_cancel <= 1'b0;
            thermal_offset      <= 2'h0;
            repair_mode         <= 1'b0;
            rate                <= RATE_1X;
            temp_update_flag    <= 1'b0;
            rd_data             <= 8'h00;
            rd_valid            <= 1'b0;
            state               <= DRRTM_IDLE;
            count               <= '0;
            tgt_bank            <= '0;
            tgt_row             <= '0;
            burn                <= 1'b0;
            repair_fault        <= 1'b0;
            repair_busy         <= 1'b0;
            derate_needed       <= 1'b0;
            temp_unsafe         <= 1'b0;
            above_85c           <= 1'b0;
        end else begin
            self_refresh_cancel <= next_self_refresh_cancel;
            thermal_offset      <= next_thermal_offset;
            repair_mode         <= next_repair_mode;
            rate                <= next_rate;
            temp_update_flag    <= next_temp_update_flag;
            rd_data             <= next_rd_data;
            rd_valid            <= next_rd_valid;
            state               <= next_state;
            count               <= next_count;
            tgt_bank            <= next_tgt_bank;
            tgt_row             <= next_tgt_row;
            burn                <= next_burn;
            repair_fault        <= next_repair_fault;
            repair_busy         <= next_repair_busy;
            derate_needed       <= next_derate_needed;
            temp_unsafe         <= next_temp_unsafe;
            above_85c           <= next_above_85c;
        end
    end
endmodule

// File: testbench/drrtm_chk.sv
// Checker on the ports of the repair and thermal mode register block.
`timescale 1ns/1ps
module drrtm_chk (
    input wire logic                  clock,
    input wire logic                  arst_n,
    input wire drrtm_pkg::drrtm_cmd_t cmd,
    input wire logic [5:0]            cmd_addr,
    input wire logic [7:0]            cmd_wdata,
    input wire logic                  cmd_read,
    input wire logic                  density_12gb,
    input wire logic                  rd_valid,
    input wire logic                  repair_mode,
    input wire logic                  repair_busy,
    input wire logic                  self_refresh_cancel,
    input wire logic [1:0]            thermal_offset,
    input wire logic                  derate_needed,
    input wire logic                  temp_unsafe,
    input wire logic                  above_85c
);
    import drrtm_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    logic mw;
    logic rd;
    logic own;
    assign mw  = cmd == DRRTM_CMD_MODE_WRITE && !cmd_read;
    assign rd  = cmd == DRRTM_CMD_MODE_WRITE && cmd_read;
    assign own = cmd_addr == ADDR_REFRESH_THERMAL_REPAIR;
    a_read_valid_pulse: assert property (rd |=> rd_valid)
        else $error("read gave no valid pulse");
    a_no_stray_valid: assert property (!rd |=> !rd_valid)
        else $error("valid pulse without a read");
    a_offset_write: assert property (mw && own && cmd_wdata[6:5] != 2'h3
        |=> thermal_offset == $past(cmd_wdata[6:5])) else $error("offset not written");
    a_offset_reserved: assert property (mw && own && cmd_wdata[6:5] == 2'h3
        |=> $stable(thermal_offset)) else $error("reserved offset taken");
    a_cancel_write: assert property (mw && own
        |=> self_refresh_cancel == ($past(cmd_wdata[3]) && $past(density_12gb)))
        else $error("self refresh cancel wrong");
    a_foreign_ignored: assert property (mw && !own
        |=> $stable({repair_mode, self_refresh_cancel, thermal_offset}))
        else $error("foreign write changed fields");
    a_busy_covers_repair: assert property (repair_mode |-> repair_busy)
        else $error("repair mode without busy");
    a_settle_hold: assert property ($fell(repair_mode) |-> repair_busy [*8])
        else $error("settle wait cut short");
    a_hot_decode: assert property (derate_needed |-> above_85c && !temp_unsafe)
        else $error("derate decode inconsistent");
    c_read: cover property (rd ##1 rd_valid);
    c_repair: cover property ($rose(repair_mode));
    c_derate: cover property ($rose(derate_needed));
endmodule
bind drrtm_mode_regs drrtm_chk u_drrtm_chk (
    .clock               (clock),
    .arst_n              (arst_n),
    .cmd                 (cmd),
    .cmd_addr            (cmd_addr),
    .cmd_wdata           (cmd_wdata),
    .cmd_read            (cmd_read),
    .density_12gb        (density_12gb),
    .rd_valid            (rd_valid),
    .repair_mode         (repair_mode),
    .repair_busy         (repair_busy),
    .self_refresh_cancel (self_refresh_cancel),
    .thermal_offset      (thermal_offset),
    .derate_needed       (derate_needed),
    .temp_unsafe         (temp_unsafe),
    .above_85c           (above_85c)
);

// File: testbench/drrtm_ctrl_model.sv
// Memory controller model issuing mode register and repair commands.
`timescale 1ns/1ps
module drrtm_ctrl_model (
    input  wire logic                 clock,
    output drrtm_pkg::drrtm_cmd_t     cmd,
    output logic [5:0]                cmd_addr,
    output logic [7:0]                cmd_wdata,
    output logic                      cmd_read,
    output logic [drrtm_pkg::BANK_W-1:0] cmd_bank,
    output logic [drrtm_pkg::ROW_W-1:0]  cmd_row,
    output logic                      all_banks_idle,
    input  wire logic [7:0]           rd_data,
    input  wire logic                 rd_valid
);
    import drrtm_pkg::*;
    initial begin
        cmd = DRRTM_CMD_NOP;
        cmd_addr = 6'h00;
        cmd_wdata = 8'h00;
        cmd_read = 1'b0;
        cmd_bank = '0;
        cmd_row = '0;
        all_banks_idle = 1'b1;
    end
    task automatic issue(input drrtm_cmd_t c, input logic [5:0] a, input logic [7:0] d,
                         input logic r);
        @(posedge clock);
        #1;
        cmd = c;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_read = r;
        @(posedge clock);
        #1;
        cmd = DRRTM_CMD_NOP;
    endtask
    task automatic mode_read(input logic [5:0] a, output logic [7:0] d, output logic v);
        issue(DRRTM_CMD_MODE_WRITE, a, 8'h00, 1'b1);
        d = rd_data;
        v = rd_valid;
    endtask
    // A fuse cannot be undone, so only entries made inside this one task go on to an activate.
    task automatic repair(input logic [2:0] b, input int prog);
        issue(DRRTM_CMD_MODE_WRITE, ADDR_REFRESH_THERMAL_REPAIR, 8'h10, 1'b0);
        repeat (10) @(posedge clock);
        #1;
        cmd_bank = b;
        cmd_row = {b, 14'h12A5};
        issue(DRRTM_CMD_ACTIVATE, 6'h00, 8'h00, 1'b0);
        repeat (prog + 2) @(posedge clock);
        issue(DRRTM_CMD_PRECHARGE, 6'h00, 8'h00, 1'b0);
        repeat (REPAIR_EXIT_CYCLES) @(posedge clock);
        issue(DRRTM_CMD_MODE_WRITE, ADDR_REFRESH_THERMAL_REPAIR, 8'h00, 1'b0);
    endtask
endmodule

// File: testbench/tb.sv
// Self-checking bench for the repair and thermal mode register block.
`timescale 1ns/1ps
module tb;
    import drrtm_pkg::*;
    localparam int PROG   = 20;
    localparam int SETTLE = 10;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic init_done = 1'b0;
    logic density_12gb = 1'b1;
    logic [2:0] sensed_rate = 3'h5;
    drrtm_cmd_t cmd;
    logic [5:0] cmd_addr;
    logic [7:0] cmd_wdata, rd_data;
    logic cmd_read, all_banks_idle, rd_valid, repair_mode, repair_busy, repair_fault;
    logic [BANK_W-1:0] cmd_bank;
    logic [ROW_W-1:0] cmd_row;
    logic self_refresh_cancel, derate_needed, temp_unsafe, above_85c;
    logic [1:0] thermal_offset;
    logic [2:0] banks [3] = '{3'h5, 3'h5, 3'h0};
    logic [7:0] spare [3] = '{8'hDF, 8'hDF, 8'hDE};
    int errors = 0;
    int n_compared = 0;
    drrtm_mode_regs #(
        .PROGRAM_CYCLES (PROG),
        .SETTLE_CYCLES  (SETTLE)
    ) u_drrtm_mode_regs (
        .clock               (clock),
        .arst_n              (arst_n),
        .cmd                 (cmd),
        .cmd_addr            (cmd_addr),
        .cmd_wdata           (cmd_wdata),
        .cmd_read            (cmd_read),
        .cmd_bank            (cmd_bank),
        .cmd_row             (cmd_row),
        .all_banks_idle      (all_banks_idle),
        .init_done           (init_done),
        .sensed_rate         (sensed_rate),
        .density_12gb        (density_12gb),
        .rd_data             (rd_data),
        .rd_valid            (rd_valid),
        .repair_mode         (repair_mode),
        .repair_busy         (repair_busy),
        .self_refresh_cancel (self_refresh_cancel),
        .thermal_offset      (thermal_offset),
        .derate_needed       (derate_needed),
        .temp_unsafe         (temp_unsafe),
        .above_85c           (above_85c),
        .repair_fault        (repair_fault)
    );
    drrtm_ctrl_model u_drrtm_ctrl_model (
        .clock          (clock),
        .cmd            (cmd),
        .cmd_addr       (cmd_addr),
        .cmd_wdata      (cmd_wdata),
        .cmd_read       (cmd_read),
        .cmd_bank       (cmd_bank),
        .cmd_row        (cmd_row),
        .all_banks_idle (all_banks_idle),
        .rd_data        (rd_data),
        .rd_valid       (rd_valid)
    );
    always #4 clock = ~clock;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s: got %h want %h", $time, msg, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string msg);
        logic [7:0] d;
        logic v;
        u_drrtm_ctrl_model.mode_read(a, d, v);
        check({7'h0, v}, 8'h01, "read valid");
        check(d, exp, msg);
    endtask
    task automatic wr(input logic [7:0] d);
        u_drrtm_ctrl_model.issue(DRRTM_CMD_MODE_WRITE, ADDR_REFRESH_THERMAL_REPAIR, d, 1'b0);
    endtask
    // The bound keeps a stuck sequencer from hanging the run.
    task automatic wait_idle;
        int i;
        for (i = 0; i < 200 && repair_busy === 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        check({7'h0, repair_busy}, 8'h00, "busy stuck");
        check({7'h0, i >= SETTLE}, 8'h01, "settle too short");
        if (repair_busy !== 1'b0) close_out();
    endtask
    initial begin
        repeat (16) @(posedge clock);
        #1;
        arst_n = 1'b1;
        rd(ADDR_REFRESH_THERMAL_REPAIR, 8'h03, "reset value");
        rd(ADDR_BANK_SPARE_ROW, SPARE_ROWS_RESET, "spare rows");
        rd(6'h05, 8'h00, "unmapped read");
        $display("Test reset values done");
        init_done = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        for (int c = 0; c < 8; c++) begin
            sensed_rate = c[2:0];
            repeat (3) @(posedge clock);
            #1;
            check({derate_needed, temp_unsafe, above_85c},
                  {c == 6, c == 0 || c == 7, c[2]}, "rate decode");
            rd(ADDR_REFRESH_THERMAL_REPAIR, {5'h10, c[2:0]}, "rate code");
        end
        rd(ADDR_REFRESH_THERMAL_REPAIR, 8'h07, "flag cleared");
        sensed_rate = 3'h3;
        repeat (3) @(posedge clock);
        rd(ADDR_REFRESH_THERMAL_REPAIR, 8'h83, "rate back");
        $display("Test thermal status done");
        wr(8'hEF);
        rd(ADDR_REFRESH_THERMAL_REPAIR, 8'h0B, "masked write");
        check({5'h00, thermal_offset, self_refresh_cancel}, 8'h01, "field outputs");
        wr(8'h40);
        rd(ADDR_REFRESH_THERMAL_REPAIR, 8'h43, "offset write");
        u_drrtm_ctrl_model.issue(DRRTM_CMD_MODE_WRITE, ADDR_BANK_SPARE_ROW, 8'hFF, 1'b0);
        rd(ADDR_REFRESH_THERMAL_REPAIR, 8'h43, "foreign write");
        density_12gb = 1'b0;
        wr(8'h08);
        rd(ADDR_REFRESH_THERMAL_REPAIR, 8'h03, "cancel gated");
        density_12gb = 1'b1;
        $display("Test writable fields done");
        foreach (banks[i]) begin
            u_drrtm_ctrl_model.repair(banks[i], PROG);
            wait_idle();
            rd(ADDR_BANK_SPARE_ROW, spare[i], "spare after repair");
            check({7'h0, repair_fault}, 8'h00, "fault raised");
        end
        $display("Test row repair done");
        // A precharge well before the program time must not burn the spare row.
        u_drrtm_ctrl_model.repair(3'h1, 0);
        wait_idle();
        rd(ADDR_BANK_SPARE_ROW, 8'hDE, "early precharge");
        check({7'h0, repair_fault}, 8'h01, "early precharge fault");
        @(posedge clock);
        #1;
        arst_n = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        arst_n = 1'b1;
        check({7'h0, repair_fault}, 8'h00, "fault after reset");
        rd(ADDR_BANK_SPARE_ROW, SPARE_ROWS_RESET, "spare after reset");
        u_drrtm_ctrl_model.all_banks_idle = 1'b0;
        wr(8'h10);
        check({6'h00, repair_mode, repair_fault}, 8'h03, "entry with open bank");
        wr(8'h00);
        u_drrtm_ctrl_model.all_banks_idle = 1'b1;
        wait_idle();
        $display("Test repair faults done");
        close_out();
    end
endmodule
